// ==== logic/rbs_pkg.sv ====
// Purpose: Shared constants and types of the reset and brown-out sequencer.
// Assumes: System clock of 50 MHz; low-frequency oscillator supplied as a tick.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
package rbs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int PUPT_TIME_MS = 64;
    localparam int LFOSC_HZ = 31000;
    localparam int PUPT_TICKS = PUPT_TIME_MS * LFOSC_HZ / 1000;
    localparam int BOR_FILTER_NS = 1000;
    localparam int BOR_FILTER_CYC = (BOR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLR_FILTER_NS = 200;
    localparam int CLR_FILTER_CYC = (CLR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_DLY_CYC = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [3:0] BCTL_OFFSET = 4'h0;
    localparam logic [3:0] PCTL_OFFSET = 4'h4;
    localparam logic [3:0] STAT_OFFSET = 4'h8;

    // Brown-out control register fields and reset values
    localparam int BCTL_SWEN_BIT = 7;
    localparam int BCTL_FAST_BIT = 6;
    localparam int BCTL_RDY_BIT = 0;
    localparam logic BCTL_SWEN_RST = 1'b1;
    localparam logic BCTL_FAST_RST = 1'b0;

    // Power control register fields
    localparam int PCTL_POR_BIT = 1;
    localparam int PCTL_BOR_BIT = 0;

    // Reset status register fields
    localparam int STAT_TO_BIT = 4;
    localparam int STAT_PD_BIT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Brown-out mode encodings
    localparam logic [1:0] BOR_MODE_ON = 2'h3;
    localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
    localparam logic [1:0] BOR_MODE_SW = 2'h1;
    localparam logic [1:0] BOR_MODE_OFF = 2'h0;

    // Erased state of the low-power monitor enable bit
    localparam logic LPBO_ERASED = 1'b1;

    // Configuration word fields used by the reset logic
    typedef struct packed {
        logic pwrup_timer_enable_n;
        logic [1:0] brownout_mode_sel;
        logic ext_clear_enable;
        logic low_volt_program;
        logic low_power_brownout;
    } rbs_cfg_t;

    // Start-up sequence states
    typedef enum logic [2:0] {
        ST_HOLD,
        ST_BOR_WAIT,
        ST_PUPT,
        ST_CLR_WAIT,
        ST_START,
        ST_RUN
    } rbs_state_t;

endpackage

// ==== logic/rbs_sequencer.sv ====
// Purpose: Reset and brown-out sequencer with a small Avalon-MM register file.
// Assumes: All inputs synchronous to clock; lfosc_tick pulses once per LF period.
// Notes: clk_en low freezes every flip-flop; core_reset_n releases execution.
// Function
// - Power-up timer of nominal 64 ms starts on power-on or brown-out reset.
// - Core held in reset while timer runs; timer enabled by low config bit.
// - Timer starts only after both power-on and brown-out requests release.
// - Mode field: 11 on, 10 off in sleep, 01 software, 00 off.
// - Brown-out reset only after supply stays low past the filter time.
// - Mode 11 waits for ready and supply at start, no wake-up delay.
// - Mode 10 waits at start, off in sleep, wake waits for ready.
// - Modes 01 and 00 release start-up without ready or supply wait.
// - Mode 01 enables the brown-out circuit from the software enable bit.
// - Software mode protects only once ready; ready shown in status bit.
// - Software mode protection unchanged by sleep entry or exit.
// - Fast-start bit always read/write; forces band gap in modes 10, 01.
// - Ready flag is read-only bit 0 of brown-out control register.
// - Low-power brown-out ORed with brown-out; feeds power and shared flag.
// - Low-power monitor enabled by config bit; erased state means enabled.
// - Clear pin enabled when clear-enable or low-voltage programming bit set.
// - Enabled clear pin low holds reset, short pulses filtered, never driven.
// - Disabled clear pin is a general input with software pull-up.
// - Watchdog timeout resets and updates timeout and power-down flags.
// - Leaving programming mode acts like a power-on reset.
// - Execution begins after timer done and clear pin released, when enabled.
// - Timer ignores clear pin; start 10 cycles after late pin release.
// - Brown-out reset clears shared flag; software sets it back.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module rbs_sequencer (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic lfosc_tick,
    // Configuration word
    input wire rbs_pkg::rbs_cfg_t cfg,
    // Supply monitors and reset sources
    input wire logic por_req,
    input wire logic supply_below,
    input wire logic bor_circuit_rdy,
    input wire logic low_power_brownout,
    input wire logic prog_exit,
    input wire logic wdt_timeout,
    input wire logic watchdog_clear_instr,
    input wire logic sleep,
    // External clear pin
    input wire logic ext_clear_pin_i,
    output logic ext_clear_pin_o,
    output logic ext_clear_pin_oe,
    input wire logic sw_pullup_en,
    output logic weak_pullup_en,
    output logic gpio_in_level,
    // Sequencer outputs
    output logic core_reset_n,
    output logic wake_stall,
    output logic brownout_reset,
    output logic bor_enable,
    output logic bandgap_force_on,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest
);

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode
    function automatic logic mode_is(input logic [1:0] m, input logic [1:0] v);
        mode_is = (m == v);
    endfunction

    logic [1:0] mode;
    logic clr_en;
    logic lpbo_en;
    logic sw_en_q, sw_en_d;
    logic fast_q, fast_d;
    logic brownout_ready;
    logic bor_filt;
    logic bor_comb;
    logic por_evt;

    assign mode = cfg.brownout_mode_sel;
    assign clr_en = cfg.ext_clear_enable | cfg.low_volt_program;
    assign lpbo_en = (cfg.low_power_brownout == rbs_pkg::LPBO_ERASED);

    // Circuit enable; sleep only matters in mode 10, never in software mode
    assign bor_enable = mode_is(mode, rbs_pkg::BOR_MODE_ON)
        | (mode_is(mode, rbs_pkg::BOR_MODE_NOSLEEP) & ~sleep)
        | (mode_is(mode, rbs_pkg::BOR_MODE_SW) & sw_en_q);
    assign brownout_ready = bor_enable & bor_circuit_rdy;
    assign bandgap_force_on = fast_q & (mode_is(mode, rbs_pkg::BOR_MODE_NOSLEEP)
        | mode_is(mode, rbs_pkg::BOR_MODE_SW));
    assign bor_comb = bor_filt | (lpbo_en & low_power_brownout);
    assign brownout_reset = bor_comb;
    assign por_evt = por_req | prog_exit;

    ////////////////////////////////////////////////////////////////////////////
    // Supply and clear pin filters
    logic [7:0] bor_cnt_q, bor_cnt_d;
    logic [7:0] clr_cnt_q, clr_cnt_d;
    logic clr_lvl_q, clr_lvl_d;
    logic gpio_q, gpio_d;

    assign bor_filt = (bor_cnt_q == 8'(rbs_pkg::BOR_FILTER_CYC));

    // Short dips restart the count, so only a sustained low trips the reset
    always_comb begin
        bor_cnt_d = 8'h00;
        if (brownout_ready && supply_below) begin
            bor_cnt_d = bor_filt ? bor_cnt_q : bor_cnt_q + 8'h01;
        end
        clr_cnt_d = 8'h00;
        clr_lvl_d = clr_lvl_q;
        if (ext_clear_pin_i != clr_lvl_q) begin
            if (clr_cnt_q == 8'(rbs_pkg::CLR_FILTER_CYC - 1)) begin
                clr_lvl_d = ext_clear_pin_i;
            end else begin
                clr_cnt_d = clr_cnt_q + 8'h01;
            end
        end
        gpio_d = clr_en ? 1'b0 : ext_clear_pin_i;
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            bor_cnt_q <= 8'h00;
            clr_cnt_q <= 8'h00;
            clr_lvl_q <= 1'b1; // Pin idles high on its pull-up
            gpio_q <= 1'b0;
        end else if (clk_en) begin
            bor_cnt_q <= bor_cnt_d;
            clr_cnt_q <= clr_cnt_d;
            clr_lvl_q <= clr_lvl_d;
            gpio_q <= gpio_d;
        end
    end

    // The pin is input only; a reset never pulls it low
    assign ext_clear_pin_o = 1'b0;
    assign ext_clear_pin_oe = 1'b0;
    assign weak_pullup_en = clr_en | sw_pullup_en;
    assign gpio_in_level = gpio_q;

    ////////////////////////////////////////////////////////////////////////////
    // Start-up sequence
    rbs_pkg::rbs_state_t st_q, st_d;
    logic [10:0] pupt_cnt_q, pupt_cnt_d;
    logic [7:0] dly_cnt_q, dly_cnt_d;
    logic wake_q, wake_d;
    logic sleep_q;
    logic core_n_q, core_n_d;
    logic clr_low;
    logic wants_bor_wait;

    assign clr_low = clr_en & ~clr_lvl_q;
    assign wants_bor_wait = mode_is(mode, rbs_pkg::BOR_MODE_ON)
        | mode_is(mode, rbs_pkg::BOR_MODE_NOSLEEP);

    // Supply events win over pin and watchdog; the timer ignores the pin
    always_comb begin
        st_d = st_q;
        pupt_cnt_d = pupt_cnt_q;
        dly_cnt_d = 8'h00;
        case (st_q)
            rbs_pkg::ST_HOLD: begin
                pupt_cnt_d = 11'h000;
                if (!por_evt && !bor_comb) begin
                    if (wants_bor_wait) begin
                        st_d = rbs_pkg::ST_BOR_WAIT;
                    end else if (!cfg.pwrup_timer_enable_n) begin
                        st_d = rbs_pkg::ST_PUPT;
                    end else begin
                        st_d = rbs_pkg::ST_CLR_WAIT;
                    end
                end
            end
            rbs_pkg::ST_BOR_WAIT: begin
                if (brownout_ready && !supply_below) begin
                    st_d = cfg.pwrup_timer_enable_n ? rbs_pkg::ST_CLR_WAIT
                        : rbs_pkg::ST_PUPT;
                end
            end
            rbs_pkg::ST_PUPT: begin
                if (lfosc_tick) begin
                    pupt_cnt_d = pupt_cnt_q + 11'h001;
                end
                if (pupt_cnt_q == 11'(rbs_pkg::PUPT_TICKS)) begin
                    st_d = rbs_pkg::ST_CLR_WAIT;
                end
            end
            rbs_pkg::ST_CLR_WAIT: begin
                if (!clr_low) begin
                    st_d = rbs_pkg::ST_START;
                end
            end
            rbs_pkg::ST_START: begin
                dly_cnt_d = dly_cnt_q + 8'h01;
                if (dly_cnt_q == 8'(rbs_pkg::START_DLY_CYC - 1)) begin
                    st_d = rbs_pkg::ST_RUN;
                end
            end
            rbs_pkg::ST_RUN: begin
                st_d = rbs_pkg::ST_RUN;
            end
            default: begin
                st_d = rbs_pkg::ST_HOLD;
            end
        endcase
        if (por_evt || bor_comb) begin
            st_d = rbs_pkg::ST_HOLD;
            dly_cnt_d = 8'h00;
        end else if (clr_low && (st_q == rbs_pkg::ST_START || st_q == rbs_pkg::ST_RUN)) begin
            st_d = rbs_pkg::ST_CLR_WAIT;
            dly_cnt_d = 8'h00;
        end else if (wdt_timeout && !sleep && st_q == rbs_pkg::ST_RUN) begin
            st_d = rbs_pkg::ST_START;
            dly_cnt_d = 8'h00;
        end
        core_n_d = (st_d == rbs_pkg::ST_RUN);
        // Wake from sleep in mode 10 stalls until the circuit is ready again
        wake_d = wake_q & ~brownout_ready;
        if (sleep_q && !sleep && mode_is(mode, rbs_pkg::BOR_MODE_NOSLEEP)) begin
            wake_d = ~brownout_ready;
        end
        if (!mode_is(mode, rbs_pkg::BOR_MODE_NOSLEEP)) begin
            wake_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_q <= rbs_pkg::ST_HOLD;
            pupt_cnt_q <= 11'h000;
            dly_cnt_q <= 8'h00;
            wake_q <= 1'b0;
            sleep_q <= 1'b0;
            core_n_q <= 1'b0;
        end else if (clk_en) begin
            st_q <= st_d;
            pupt_cnt_q <= pupt_cnt_d;
            dly_cnt_q <= dly_cnt_d;
            wake_q <= wake_d;
            sleep_q <= sleep;
            core_n_q <= core_n_d;
        end
    end

    assign core_reset_n = core_n_q;
    assign wake_stall = wake_q;

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave and flags; one wait state on every access
    logic ack_q, ack_d;
    logic [31:0] rdata_q, rdata_d;
    logic por_n_q, por_n_d;
    logic bor_n_q, bor_n_d;
    logic to_n_q, to_n_d;
    logic pd_n_q, pd_n_d;
    logic wr_now;

    assign waitrequest = (read | write) & ~ack_q;
    assign wr_now = write & ack_q & byteenable[0];

    // Hardware clears are applied after the software write, so events win
    always_comb begin
        ack_d = (read | write) & ~ack_q;
        rdata_d = rdata_q;
        sw_en_d = sw_en_q;
        fast_d = fast_q;
        por_n_d = por_n_q;
        bor_n_d = bor_n_q;
        to_n_d = to_n_q;
        pd_n_d = pd_n_q;
        if (ack_d && read) begin
            rdata_d = 32'h0000_0000;
            case (address)
                rbs_pkg::BCTL_OFFSET: begin
                    rdata_d[rbs_pkg::BCTL_SWEN_BIT] = sw_en_q;
                    rdata_d[rbs_pkg::BCTL_FAST_BIT] = fast_q;
                    rdata_d[rbs_pkg::BCTL_RDY_BIT] = brownout_ready;
                end
                rbs_pkg::PCTL_OFFSET: begin
                    rdata_d[rbs_pkg::PCTL_POR_BIT] = por_n_q;
                    rdata_d[rbs_pkg::PCTL_BOR_BIT] = bor_n_q;
                end
                rbs_pkg::STAT_OFFSET: begin
                    rdata_d[rbs_pkg::STAT_TO_BIT] = to_n_q;
                    rdata_d[rbs_pkg::STAT_PD_BIT] = pd_n_q;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
        if (wr_now && address == rbs_pkg::BCTL_OFFSET) begin
            sw_en_d = writedata[rbs_pkg::BCTL_SWEN_BIT];
            fast_d = writedata[rbs_pkg::BCTL_FAST_BIT];
        end
        if (wr_now && address == rbs_pkg::PCTL_OFFSET) begin
            por_n_d = writedata[rbs_pkg::PCTL_POR_BIT];
            bor_n_d = writedata[rbs_pkg::PCTL_BOR_BIT];
        end
        if (watchdog_clear_instr) begin
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
        end
        if (sleep && !sleep_q) begin
            to_n_d = 1'b1;
            pd_n_d = 1'b0;
        end
        if (wdt_timeout) begin
            to_n_d = 1'b0;
            pd_n_d = sleep ? 1'b0 : pd_n_d;
        end
        if (bor_comb) begin
            bor_n_d = 1'b0;
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
        end
        if (por_evt) begin
            por_n_d = 1'b0;
            bor_n_d = 1'b0;
            to_n_d = 1'b1;
            pd_n_d = 1'b1;
            sw_en_d = rbs_pkg::BCTL_SWEN_RST;
            fast_d = rbs_pkg::BCTL_FAST_RST;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            sw_en_q <= rbs_pkg::BCTL_SWEN_RST;
            fast_q <= rbs_pkg::BCTL_FAST_RST;
            por_n_q <= 1'b0;
            bor_n_q <= 1'b0;
            to_n_q <= 1'b1;
            pd_n_q <= 1'b1;
        end else if (clk_en) begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            sw_en_q <= sw_en_d;
            fast_q <= fast_d;
            por_n_q <= por_n_d;
            bor_n_q <= bor_n_d;
            to_n_q <= to_n_d;
            pd_n_q <= pd_n_d;
        end
    end

    assign readdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    mode_off_a: assert property (@(posedge clock) disable iff (!rstn)
        mode_is(mode, rbs_pkg::BOR_MODE_OFF) |-> !bor_enable)
        else $error("brown-out enabled in off mode");
    sw_enable_a: assert property (@(posedge clock) disable iff (!rstn)
        mode_is(mode, rbs_pkg::BOR_MODE_SW) |-> (bor_enable == sw_en_q))
        else $error("software mode enable mismatch");
    fast_start_a: assert property (@(posedge clock) disable iff (!rstn)
        (mode_is(mode, rbs_pkg::BOR_MODE_ON) || mode_is(mode, rbs_pkg::BOR_MODE_OFF))
        |-> !bandgap_force_on)
        else $error("fast start active in always-on or off mode");
    bor_filter_a: assert property (@(posedge clock) disable iff (!rstn || !clk_en)
        !supply_below |=> !bor_filt)
        else $error("brown-out tripped without low supply");
    timer_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        (st_q == rbs_pkg::ST_PUPT) |=> !core_reset_n)
        else $error("core released while timer runs");
    start_delay_a: assert property (@(posedge clock) disable iff (!rstn || !clk_en)
        (st_q == rbs_pkg::ST_CLR_WAIT && !clr_low && !por_evt && !bor_comb)
        |=> (!core_reset_n)[*5] ##1 (!core_reset_n)[*5] ##1 core_reset_n)
        else $error("start delay not ten cycles");
    lpbo_flag_a: assert property (@(posedge clock) disable iff (!rstn || !clk_en)
        (lpbo_en && low_power_brownout) |=> !bor_n_q && (st_q == rbs_pkg::ST_HOLD))
        else $error("low-power brown-out not merged");
    pin_undriven_a: assert property (@(posedge clock) disable iff (!rstn)
        !ext_clear_pin_oe)
        else $error("clear pin driven");
    wdt_flag_a: assert property (@(posedge clock) disable iff (!rstn || !clk_en)
        (wdt_timeout && !por_evt && !bor_comb) |=> !to_n_q)
        else $error("timeout flag not cleared by watchdog");

endmodule

// ==== verification/rbs_partner.sv ====
// Purpose: Far-side model: brown-out analog ready and the clear pin wire.
// Assumes: The bench asks for a low pin through pin_low_req.
// Notes: An undriven, unpulled pin toggles every cycle so no stale level passes.
`timescale 1ns/1ps
module rbs_partner #(
    parameter int RDY_DLY = 5
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // From the sequencer
    input wire logic bor_enable,
    input wire logic weak_pullup_en,
    input wire logic pin_o,
    input wire logic pin_oe,
    // From the bench
    input wire logic pin_low_req,
    // To the sequencer
    output logic bor_circuit_rdy,
    output logic pin_level
);
    int rdy_cnt;
    logic float_q;

    ////////////////////////////////////////////////////////////////////////////
    // Ready lags enable: the analog circuit needs time to settle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdy_cnt <= 0;
            float_q <= 1'b0;
        end else begin
            rdy_cnt <= !bor_enable ? 0 : (rdy_cnt < RDY_DLY) ? rdy_cnt + 1 : rdy_cnt;
            float_q <= !float_q;
        end
    end
    assign bor_circuit_rdy = (rdy_cnt == RDY_DLY);

    // Wire level; the pull-up only wins when nobody pulls the pin low
    assign pin_level = pin_oe ? pin_o : pin_low_req ? 1'b0 : weak_pullup_en ? 1'b1 : float_q;
endmodule

// ==== verification/rbs_sequencer_tb_top.sv ====
// Purpose: Self-checking bench for the reset and brown-out sequencer.
// Assumes: lfosc_tick held high, so the power-up count runs at clock rate.
// Notes: Random dip and pulse lengths stay below the filter spans.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module rbs_sequencer_tb_top;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    rbs_pkg::rbs_cfg_t cfg = '{1'b0, 2'h3, 1'b1, 1'b0, 1'b1};
    logic por_req = 1'b1, supply_below = 1'b0, lpbo_req = 1'b0, prog_exit = 1'b0;
    logic wdt_timeout = 1'b0, wdt_clr = 1'b0, sleep = 1'b0, sw_pullup_en = 1'b0;
    logic pin_low_req = 1'b1, read = 1'b0, write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, rd;
    logic bor_circuit_rdy, pin_i, pin_o, pin_oe, weak_pullup_en, gpio_in_level;
    logic core_reset_n, wake_stall, brownout_reset, bor_enable, bandgap_force_on;
    logic waitrequest;
    int failures = 0;
    int checks_done = 0;
    int n;

    always #10 clock = ~clock;

    rbs_sequencer dut (.clock(clock), .rstn(rstn), .clk_en(1'b1), .lfosc_tick(1'b1),
        .cfg(cfg), .por_req(por_req), .supply_below(supply_below),
        .bor_circuit_rdy(bor_circuit_rdy), .low_power_brownout(lpbo_req),
        .prog_exit(prog_exit), .wdt_timeout(wdt_timeout), .watchdog_clear_instr(wdt_clr),
        .sleep(sleep), .ext_clear_pin_i(pin_i), .ext_clear_pin_o(pin_o),
        .ext_clear_pin_oe(pin_oe), .sw_pullup_en(sw_pullup_en),
        .weak_pullup_en(weak_pullup_en), .gpio_in_level(gpio_in_level),
        .core_reset_n(core_reset_n), .wake_stall(wake_stall),
        .brownout_reset(brownout_reset), .bor_enable(bor_enable),
        .bandgap_force_on(bandgap_force_on), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
        .waitrequest(waitrequest));

    rbs_partner partner (.clock(clock), .rstn(rstn), .bor_enable(bor_enable),
        .weak_pullup_en(weak_pullup_en), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_low_req(pin_low_req), .bor_circuit_rdy(bor_circuit_rdy), .pin_level(pin_i));

    ////////////////////////////////////////////////////////////////////////////
    // Expected brown-out circuit enable for a mode, sleep state and software bit
    function automatic logic exp_en(logic [1:0] m, logic slp, logic sw);
        return (m == rbs_pkg::BOR_MODE_ON) || (m == rbs_pkg::BOR_MODE_NOSLEEP && !slp)
            || (m == rbs_pkg::BOR_MODE_SW && sw);
    endfunction

    task automatic tick(input int c);
        repeat (c) @(posedge clock);
    endtask

    // One Avalon access; an idle edge after it keeps back-to-back calls race free
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        k = 0;
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 50);
        if (k == 50) failures++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    // Counts edges until execution is released, bounded
    task automatic wait_run(input int max, output int cnt);
        cnt = 0;
        while (core_reset_n !== 1'b1 && cnt < max) begin
            @(posedge clock);
            cnt++;
        end
        if (cnt == max) failures++;
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Hang guard, about seven times the expected run length
    initial begin
        #1_200_000;
        failures++;
        test_done();
    end

    // Main sequence
    initial begin
        void'($urandom(69));
        tick(4);
        rstn <= 1'b1;
        bus(1'b0, rbs_pkg::BCTL_OFFSET, 0, rd);
        `CHK(rd[7:6], 2'b10)
        bus(1'b0, rbs_pkg::PCTL_OFFSET, 0, rd);
        `CHK(rd[1:0], 2'b00)
        bus(1'b0, rbs_pkg::STAT_OFFSET, 0, rd);
        `CHK(rd[4:3], 2'b11)
        bus(1'b1, 4'hc, 32'hffff_ffff, rd);
        bus(1'b0, 4'hc, 0, rd);
        `CHK(rd, 32'h0000_0000)
        // Power-on with the clear pin held low past the power-up count
        por_req <= 1'b0;
        tick(2000);
        `CHK(core_reset_n, 1'b0)
        pin_low_req <= 1'b0;
        tick(10);
        `CHK(core_reset_n, 1'b0)
        wait_run(30, n);
        `CHK(core_reset_n, 1'b1)
        `CHK(pin_oe, 1'b0)
        `CHK(pin_o, 1'b0)
        // Fast start is writable, ready ignores writes
        bus(1'b1, rbs_pkg::BCTL_OFFSET, 32'h0000_0040, rd);
        bus(1'b0, rbs_pkg::BCTL_OFFSET, 0, rd);
        `CHK(rd[7:0], 8'h41)
        // Short clear pulses are filtered, a long one resets
        repeat (6) begin
            pin_low_req <= 1'b1;
            tick($urandom_range(1, 8));
            pin_low_req <= 1'b0;
            tick(12);
            `CHK(core_reset_n, 1'b1)
        end
        pin_low_req <= 1'b1;
        tick(20);
        `CHK(core_reset_n, 1'b0)
        pin_low_req <= 1'b0;
        wait_run(40, n);
        `CHK(core_reset_n, 1'b1)
        // Clear function off: pin is a plain input with software pull-up
        cfg.ext_clear_enable <= 1'b0;
        sw_pullup_en <= 1'b1;
        pin_low_req <= 1'b1;
        tick(20);
        `CHK(core_reset_n, 1'b1)
        `CHK(gpio_in_level, 1'b0)
        `CHK(weak_pullup_en, 1'b1)
        pin_low_req <= 1'b0;
        tick(3);
        `CHK(gpio_in_level, 1'b1)
        sw_pullup_en <= 1'b0;
        tick(1);
        `CHK(weak_pullup_en, 1'b0)
        cfg.low_volt_program <= 1'b1;
        pin_low_req <= 1'b1;
        tick(20);
        `CHK(core_reset_n, 1'b0)
        pin_low_req <= 1'b0;
        cfg.low_volt_program <= 1'b0;
        cfg.ext_clear_enable <= 1'b1;
        wait_run(40, n);
        // Watchdog timeout while awake
        wdt_timeout <= 1'b1;
        tick(1);
        wdt_timeout <= 1'b0;
        tick(2);
        `CHK(core_reset_n, 1'b0)
        wait_run(2100, n);
        bus(1'b0, rbs_pkg::STAT_OFFSET, 0, rd);
        `CHK(rd[4:3], 2'b01)
        wdt_clr <= 1'b1;
        tick(1);
        wdt_clr <= 1'b0;
        bus(1'b0, rbs_pkg::STAT_OFFSET, 0, rd);
        `CHK(rd[4:3], 2'b11)
        // Supply dips: short ones ignored, a long one resets and reruns the timer
        bus(1'b1, rbs_pkg::PCTL_OFFSET, 32'h0000_0003, rd);
        repeat (8) begin
            supply_below <= 1'b1;
            repeat ($urandom_range(1, 40)) begin
                @(posedge clock);
                `CHK(brownout_reset, 1'b0)
            end
            supply_below <= 1'b0;
            tick(2);
        end
        supply_below <= 1'b1;
        tick(60);
        `CHK(brownout_reset, 1'b1)
        `CHK(core_reset_n, 1'b0)
        supply_below <= 1'b0;
        wait_run(2100, n);
        `CHK(n >= 1994 && n <= 2040, 1'b1)
        bus(1'b0, rbs_pkg::PCTL_OFFSET, 0, rd);
        `CHK(rd[1:0], 2'b10)
        // Low-power monitor request joins the brown-out reset
        lpbo_req <= 1'b1;
        tick(2);
        `CHK(brownout_reset, 1'b1)
        cfg.low_power_brownout <= 1'b0;
        tick(1);
        `CHK(brownout_reset, 1'b0)
        lpbo_req <= 1'b0;
        cfg.low_power_brownout <= 1'b1;
        wait_run(2100, n);
        // Every mode, asleep and awake, with software enable and fast start set
        bus(1'b1, rbs_pkg::BCTL_OFFSET, 32'h0000_00c0, rd);
        for (int m = 0; m < 4; m++) begin
            for (int j = 0; j < 2; j++) begin
                cfg.brownout_mode_sel <= 2'(m);
                sleep <= 1'(1 - j);
                tick(10);
                `CHK(bor_enable, exp_en(2'(m), 1'(1 - j), 1'b1))
                `CHK(bandgap_force_on, 1'(m == 1 || m == 2))
                if (m == 3) `CHK(wake_stall, 1'b0)
            end
        end
        // Mode 10 wake-up waits for ready
        cfg.brownout_mode_sel <= rbs_pkg::BOR_MODE_NOSLEEP;
        sleep <= 1'b1;
        tick(10);
        `CHK(bor_enable, 1'b0)
        sleep <= 1'b0;
        tick(3);
        `CHK(wake_stall, 1'b1)
        tick(12);
        `CHK(wake_stall, 1'b0)
        // Software mode follows the enable bit, ready shows in bit 0
        cfg.brownout_mode_sel <= rbs_pkg::BOR_MODE_SW;
        bus(1'b1, rbs_pkg::BCTL_OFFSET, 32'h0000_0000, rd);
        tick(8);
        `CHK(bor_enable, 1'b0)
        bus(1'b0, rbs_pkg::BCTL_OFFSET, 0, rd);
        `CHK(rd[0], 1'b0)
        bus(1'b1, rbs_pkg::BCTL_OFFSET, 32'h0000_0080, rd);
        tick(8);
        bus(1'b0, rbs_pkg::BCTL_OFFSET, 0, rd);
        `CHK(rd[0], 1'b1)
        // Leaving programming mode behaves as power-on
        cfg.brownout_mode_sel <= rbs_pkg::BOR_MODE_ON;
        bus(1'b1, rbs_pkg::PCTL_OFFSET, 32'h0000_0003, rd);
        prog_exit <= 1'b1;
        tick(1);
        prog_exit <= 1'b0;
        tick(2);
        `CHK(core_reset_n, 1'b0)
        wait_run(2100, n);
        `CHK(n >= 1984, 1'b1)
        bus(1'b0, rbs_pkg::PCTL_OFFSET, 0, rd);
        `CHK(rd[1:0], 2'b00)
        test_done();
    end
endmodule
